/* verilog/giq_regs.svh */
`ifndef GIQ_REGS_SVH
`define GIQ_REGS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define GIQ_ADDR_W 4
`define GIQ_OFS_CTRL 4'h0
`define GIQ_OFS_QSEL 4'h4
`define GIQ_OFS_MODE 4'h8
`define GIQ_OFS_DATA 4'hC

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define GIQ_PRD_W 8
`define GIQ_CTRL_RST 32'h0000_0000
`define GIQ_QSEL_RST 32'h0000_0000
`define GIQ_MODE_RST 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define GIQ_SYNC_STAGES 2
`define GIQ_SAMPLES_SHORT 3
`define GIQ_SAMPLES_LONG 6

`endif

/* verilog/giq_pkg.sv */
package giq_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } giq_bus_req_t;
endpackage

/* verilog/giq_pin_filter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "giq_regs.svh"
module giq_pin_filter import giq_pkg::*; (
    input wire logic core_clk, // System clock
    input wire logic sys_rst, // Async reset
    input wire logic pin_sync, // Synchronised pin level
    input wire logic sample_en, // Group sample pulse
    input wire logic qualify, // Use sampled qualification
    input wire logic six_samples, // Six rather than three samples
    output logic level_q // Qualified level
);
    logic [5:0] hist_q;
    logic all_hi;
    logic all_lo;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hist_q <= 6'h00;
        end else if (sample_en) begin
            hist_q <= {hist_q[4:0], pin_sync};
        end
    end

    // Three samples span two periods, six span five
    always_comb begin
        if (six_samples) begin
            all_hi = &{hist_q[4:0], pin_sync};
            all_lo = ~|{hist_q[4:0], pin_sync};
        end else begin
            all_hi = &{hist_q[1:0], pin_sync};
            all_lo = ~|{hist_q[1:0], pin_sync};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (!qualify) begin
            level_q <= pin_sync;
        end else if (sample_en && all_hi) begin
            level_q <= 1'b1;
        end else if (sample_en && all_lo) begin
            level_q <= 1'b0;
        end
    end

    property p_hold_unless_agree;
        @(posedge core_clk) disable iff (sys_rst)
        (qualify && $past(qualify) && !$past(sample_en)) |-> $stable(level_q);
    endproperty
    a_hold_unless_agree: assert property (p_hold_unless_agree)
        else $error("level changed without a sample");

    property p_rise_needs_high;
        @(posedge core_clk) disable iff (sys_rst)
        (qualify && $past(qualify) && $rose(level_q)) |-> $past(pin_sync);
    endproperty
    a_rise_needs_high: assert property (p_rise_needs_high)
        else $error("level rose on a low sample");

    property p_fall_needs_low;
        @(posedge core_clk) disable iff (sys_rst)
        (qualify && $past(qualify) && $fell(level_q)) |-> !$past(pin_sync);
    endproperty
    a_fall_needs_low: assert property (p_fall_needs_low)
        else $error("level fell on a high sample");

    property p_sync_follows;
        @(posedge core_clk) disable iff (sys_rst)
        (!qualify) |=> (level_q == $past(pin_sync));
    endproperty
    a_sync_follows: assert property (p_sync_follows)
        else $error("synchronous mode did not follow pin");
endmodule
`default_nettype wire

/* verilog/giq_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "giq_regs.svh"
module giq_top import giq_pkg::*; #(
    parameter int GROUPS = 4
) (
    input wire logic core_clk, // 25 MHz system clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic [3:0] bus_addr, // Register address
    input wire logic [31:0] bus_wdata, // Write data
    input wire logic bus_wr, // Write strobe
    input wire logic bus_rd, // Read strobe
    output logic [31:0] bus_rdata, // Read data, cycle after strobe
    input wire logic [GROUPS*8-1:0] pin_in, // Asynchronous pins
    output logic [GROUPS*8-1:0] pin_qual // Qualified levels
);
    localparam int N = GROUPS * 8;

    giq_bus_req_t req;
    logic [31:0] port_qual_control_reg_q; // one period byte per group
    logic [31:0] qual_sample_select_reg_q;
    logic [31:0] qual_mode_reg_q;
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [GROUPS-1:0] tick;

    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_qual_control_reg_q <= `GIQ_CTRL_RST;
            qual_sample_select_reg_q <= `GIQ_QSEL_RST;
            qual_mode_reg_q <= `GIQ_MODE_RST;
        end else if (req.wr) begin
            if (req.addr == `GIQ_OFS_CTRL) begin
                port_qual_control_reg_q <= req.wdata;
            end else if (req.addr == `GIQ_OFS_QSEL) begin
                qual_sample_select_reg_q <= req.wdata;
            end else if (req.addr == `GIQ_OFS_MODE) begin
                qual_mode_reg_q <= req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            if (req.addr == `GIQ_OFS_CTRL) begin
                bus_rdata <= port_qual_control_reg_q;
            end else if (req.addr == `GIQ_OFS_QSEL) begin
                bus_rdata <= qual_sample_select_reg_q;
            end else if (req.addr == `GIQ_OFS_MODE) begin
                bus_rdata <= qual_mode_reg_q;
            end else if (req.addr == `GIQ_OFS_DATA) begin
                bus_rdata <= 32'(pin_qual);
            end else begin
                bus_rdata <= 32'h0000_0000;
            end
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------
    // Group sample dividers
    // ----------------------------------------
    // Counter reloads at 2n-1, or 0 when n is 0; period change takes effect on next wrap
    for (genvar g = 0; g < GROUPS; g++) begin : g_div
        logic [7:0] prd;
        logic [8:0] cnt_q;
        assign prd = port_qual_control_reg_q[g*8 +: 8];
        assign tick[g] = (cnt_q == 9'h000);
        always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
                cnt_q <= 9'h000;
            end else if (tick[g]) begin
                if (prd == 8'h00) begin
                    cnt_q <= 9'h000;
                end else begin
                    cnt_q <= {prd, 1'b0} - 9'h001;
                end
            end else begin
                cnt_q <= cnt_q - 9'h001;
            end
        end

        sequence s_gap_then_tick;
            !tick[g] ##1 tick[g];
        endsequence

        property p_tick_spacing;
            @(posedge core_clk) disable iff (sys_rst)
            (tick[g] && prd == 8'h01 && $stable(prd)) |=> s_gap_then_tick;
        endproperty
        a_tick_spacing: assert property (p_tick_spacing)
            else $error("period one did not tick every two clocks");

        property p_tick_zero;
            @(posedge core_clk) disable iff (sys_rst)
            (tick[g] && prd == 8'h00) |=> tick[g];
        endproperty
        a_tick_zero: assert property (p_tick_zero)
            else $error("period zero did not tick each clock");
    end

    for (genvar i = 0; i < N; i++) begin : g_pin
        giq_pin_filter u_filt (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .pin_sync(sync2_q[i]),
            .sample_en(tick[i/8]),
            .qualify(qual_mode_reg_q[i]),
            .six_samples(qual_sample_select_reg_q[i]),
            .level_q(pin_qual[i])
        );
    end
endmodule
`default_nettype wire

/* tb/giq_pin_src.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External source on the pins
// ----------------------------------------
module giq_pin_src #(
    parameter int N = 32
) (
    input wire logic core_clk, // System clock
    output logic [N-1:0] pin // Driven pin levels
);
    initial pin = '0;
    // Whole-cycle levels only; width per pin never below what is asked
    task automatic pulse(input int w[N], input int span, input logic pol);
        for (int k = 0; k < span; k++) begin
            @(posedge core_clk);
            for (int i = 0; i < N; i++) begin
                pin[i] <= pol ^ (k < w[i]);
            end
        end
    endtask
endmodule
`default_nettype wire

/* tb/gpio_input_qualifier_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_input_qualifier_tb;
    import giq_pkg::*;
    localparam int N = 32;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    giq_bus_req_t req = '0;
    logic [31:0] bus_rdata;
    logic [N-1:0] pin_in, pin_qual, seen, expv;
    logic clr = 1'b0;
    logic pol = 1'b0;
    int n_fail = 0;
    int samples_checked = 0;
    int w[N];
    int z[N] = '{default: 0};
    logic [31:0] ctrl, qsel, mode, rd;

    giq_top #(.GROUPS(4)) giq_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_addr(req.addr), .bus_wdata(req.wdata), .bus_wr(req.wr), .bus_rd(req.rd),
        .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_qual(pin_qual));
    giq_pin_src #(.N(N)) giq_pin_src_i (.core_clk(core_clk), .pin(pin_in));

    initial forever #20 core_clk = ~core_clk;
    // Sticky record of any departure from the idle level
    always @(posedge core_clk) seen <= clr ? '0 : seen | (pin_qual ^ {N{pol}});

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    function automatic int sp_of(input logic [7:0] n);
        return (n == 8'h00) ? 1 : 2 * n;
    endfunction
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int sp, win, span;
        void'($urandom(32'h6f51));
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_wr(4'h2, 32'hFFFF_FFFF);
        reg_rd(4'h2, rd);
        check(rd, 32'h0);
        // Unmapped write must not land in the period register
        reg_rd(4'h0, rd);
        check(rd, 32'h0);
        for (int t = 0; t < 12; t++) begin
            // First test puts the top period value on one group
            ctrl = (t == 0) ? 32'h01FF_0002 : $urandom & 32'h0303_0303;
            qsel = $urandom;
            mode = (t < 2) ? 32'hFFFF_FFFF : $urandom;
            pol <= t[0];
            reg_wr(4'h0, ctrl);
            reg_wr(4'h4, qsel);
            reg_wr(4'h8, mode);
            reg_rd(4'h0, rd);
            check(rd, ctrl);
            reg_rd(4'h4, rd);
            check(rd, qsel);
            reg_rd(4'h8, rd);
            check(rd, mode);
            span = 0;
            for (int i = 0; i < N; i++) begin
                sp = sp_of(ctrl[8*(i/8) +: 8]);
                win = sp * (qsel[i] ? 5 : 2);
                expv[i] = mode[i] ? 1'($urandom % 2) : 1'b1;
                w[i] = !mode[i] ? 2 : (expv[i] ? win + sp + 1 : win);
                span = (2 * w[i] + 520 > span) ? 2 * w[i] + 520 : span;
            end
            // Long idle lets an old period expire before the pulse
            giq_pin_src_i.pulse(z, span, pol);
            check(pin_qual, {N{pol}});
            reg_rd(4'hC, rd);
            check(rd, {N{pol}});
            clr <= 1'b1;
            @(posedge core_clk);
            clr <= 1'b0;
            giq_pin_src_i.pulse(w, span, pol);
            check(seen, expv);
            $display("Test %0d done", t);
        end
        // Mid-run reset must clear outputs and every register
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(pin_qual, 32'h0);
        sys_rst <= 1'b0;
        reg_rd(4'h0, rd);
        check(rd, 32'h0);
        reg_rd(4'h4, rd);
        check(rd, 32'h0);
        reg_rd(4'h8, rd);
        check(rd, 32'h0);
        $display("Reset test done");
        summarize();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
